//--- hw/rco_pkg.sv
// constants, register map and types for the reference clock output block
// Notes on behaviour
// [RL1] Generated clock drives the output pin and the same signal goes to on-chip users.
// [RL2] Source codes 0-4: system, high, low, medium 500 kHz, medium 32 kHz oscillators.
// [RL3] Codes 5-11: secondary crystal, external, numeric osc, logic cells 1-4; 12-15 reserved.
// [RL4] Control bit 7 set starts the module and output; clear stops it.
// [RL5] Output starts glitch-free: first pulse after enable is a full period.
// [RL6] Clearing the enable bit turns the output off at once.
// [RL7] Divider field divides base clock by two to the field value, 1 to 128.
// [RL8] Nonzero divider: duty 11 gives 75%, 10 gives 50%, 01 gives 25%, 00 low.
// [RL9] Divider 000: any nonzero duty gives 50%; duty 00 stays low.
// [RL10] Reset loads duty 10, enable 0 and divider 0.
// [RL11] Software changes divider and duty only while disabled, else pulses may corrupt.
// [RL12] Output keeps running in sleep unless the system oscillator is selected.
// [RL13] Module disable holds block in reset, outputs off, writes ignored, reads zero.
// [RL14] Unused control bits 6:5 and select bits 7:4 read zero; source resets to 0.
package rco_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'h296;
  localparam logic [11:0] IDX_SRC = 12'h297;
  localparam int ADDR_W = 14;
  localparam logic [13:0] ADR_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [13:0] ADR_SRC = {IDX_SRC, 2'h0};
  // control and source select register fields
  localparam int EN_BIT = 7;
  localparam int DUTY_LSB = 3;
  localparam int DUTY_MSB = 4;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  localparam int SEL_MSB = 3;
  localparam logic [1:0] DUTY_RST = 2'h2;
  localparam logic [1:0] DUTY_OFF = 2'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [7:0] CTRL_RST = 8'h10;
  // source codes
  localparam logic [3:0] SRC_SYSOSC = 4'h0;
  localparam logic [3:0] SRC_HFOSC = 4'h1;
  localparam logic [3:0] SRC_LFOSC = 4'h2;
  localparam logic [3:0] SRC_MF500 = 4'h3;
  localparam logic [3:0] SRC_MF32 = 4'h4;
  localparam logic [3:0] SRC_SECONDARY_CRYSTAL_OSC = 4'h5;
  localparam logic [3:0] SRC_EXTERNAL_OSC = 4'h6;
  localparam logic [3:0] SRC_NUMOSC = 4'h7;
  localparam logic [3:0] SRC_CELL1 = 4'h8;
  localparam logic [3:0] SRC_RSVD_MIN = 4'hC;
  localparam int NUM_SRC = 12;
  // half-period counter width: 128 base periods is 256 half periods
  localparam int HCNT_W = 8;
  typedef enum logic [1:0] {WV_IDLE, WV_ARM, WV_RUN} rco_wave_e;
endpackage

//--- hw/rco_src_sel.sv
// source multiplexer and base clock edge detector
`timescale 1ns/1ps
module rco_src_sel (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [rco_pkg::NUM_SRC-1:0] src_i,
  input wire logic [3:0] sel_i,
  input wire logic sleep_i,
  output logic rise_o,
  output logic fall_o
);
  logic lvl_r;
  logic prev_r;
  logic pick;
  logic frozen;

  // reserved codes select a constant low level
  // [RL2] [RL3] source code decode
  always_comb
  begin
    pick = 1'b0;
    if (sel_i < rco_pkg::SRC_RSVD_MIN)
    begin
      pick = src_i[sel_i];
    end
  end

  // the system oscillator stops in sleep, so its level freezes
  // [RL12] sleep freeze
  assign frozen = sleep_i && (sel_i == rco_pkg::SRC_SYSOSC);

  // sources are synchronous, so one stage is enough for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lvl_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      lvl_r <= frozen ? lvl_r : pick;
      prev_r <= lvl_r;
    end
  end

  assign rise_o = lvl_r & ~prev_r;
  assign fall_o = ~lvl_r & prev_r;

  property p_src_route;
    @(posedge sys_clk) disable iff (!rst_n)
    (!frozen && sel_i < rco_pkg::SRC_RSVD_MIN) |=> lvl_r == $past(src_i[sel_i]);
  endproperty
  a_src_route: assert property (p_src_route) else $error("selected source not routed"); // RL2

  property p_src_rsvd;
    @(posedge sys_clk) disable iff (!rst_n)
    (sel_i >= rco_pkg::SRC_RSVD_MIN) |=> !lvl_r;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("reserved source not low"); // RL3

  property p_sleep_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    frozen |=> $stable(lvl_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("system source moved in sleep"); // RL12
endmodule

//--- hw/rco_wave.sv
// divider and duty cycle shaper counting base clock half periods
`timescale 1ns/1ps
module rco_wave (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic en_i,
  input wire logic [1:0] duty_i,
  input wire logic [2:0] div_i,
  input wire logic rise_i,
  input wire logic fall_i,
  output logic out_r
);
  rco_pkg::rco_wave_e st_r;
  logic [rco_pkg::HCNT_W-1:0] h_r;
  logic [rco_pkg::HCNT_W-1:0] last;
  logic [rco_pkg::HCNT_W-1:0] h_nxt;
  logic [rco_pkg::HCNT_W:0] thresh;
  logic edge_any;

  // [RL7] period of two to the div plus one half periods
  assign last = rco_pkg::HCNT_W'((9'h002 << div_i) - 9'h001);
  // >= keeps the count bounded if div shrinks while running
  assign h_nxt = (h_r >= last) ? '0 : h_r + 8'h01;
  assign edge_any = rise_i | fall_i;

  // high time in half periods; quarters are exact since a period with a nonzero divider has at least four
  // [RL8] [RL9] duty threshold
  always_comb
  begin
    thresh = '0;
    if (duty_i == rco_pkg::DUTY_OFF)
    begin
      thresh = '0;
    end
    else if (div_i == 3'h0)
    begin
      thresh = 9'h001;
    end
    else
    begin
      thresh = {7'h00, duty_i} << (div_i - 3'h1);
    end
  end

  // state, counter and output
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_r <= rco_pkg::WV_IDLE;
      h_r <= '0;
      out_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        rco_pkg::WV_IDLE:
        begin
          h_r <= '0;
          out_r <= 1'b0;
          if (en_i)
          begin
            st_r <= rco_pkg::WV_ARM;
          end
        end
        // [RL5] start on a rising base edge
        rco_pkg::WV_ARM:
        begin
          if (!en_i)
          begin
            st_r <= rco_pkg::WV_IDLE;
          end
          else if (rise_i)
          begin
            st_r <= rco_pkg::WV_RUN;
            h_r <= '0;
            out_r <= (thresh != '0);
          end
        end
        rco_pkg::WV_RUN:
        begin
          // [RL6] immediate stop
          if (!en_i)
          begin
            st_r <= rco_pkg::WV_IDLE;
            out_r <= 1'b0;
          end
          else if (edge_any)
          begin
            h_r <= h_nxt;
            out_r <= ({1'b0, h_nxt} < thresh);
          end
        end
        default:
        begin
          st_r <= rco_pkg::WV_IDLE;
          out_r <= 1'b0;
        end
      endcase
    end
  end

  property p_stop_now;
    @(posedge sys_clk) disable iff (!rst_n)
    !en_i |=> !out_r;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("output not stopped"); // RL6

  sequence s_armed;
    st_r == rco_pkg::WV_ARM && en_i;
  endsequence
  sequence s_first_rise;
    rise_i && thresh != '0;
  endsequence
  property p_clean_start;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(out_r) |-> $past(rise_i) && $past(st_r) != rco_pkg::WV_IDLE;
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("output rose off a base edge"); // RL5

  property p_arm_go;
    @(posedge sys_clk) disable iff (!rst_n)
    s_armed ##0 s_first_rise |=> out_r && h_r == '0;
  endproperty
  a_arm_go: assert property (p_arm_go) else $error("first pulse missing"); // RL5

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r == rco_pkg::WV_RUN && en_i && edge_any && h_r == last) |=> h_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider period wrong"); // RL7

  property p_duty_off;
    @(posedge sys_clk) disable iff (!rst_n)
    duty_i == rco_pkg::DUTY_OFF |=> !out_r;
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("duty 00 not low"); // RL8

  property p_div0_half;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r == rco_pkg::WV_RUN && en_i && div_i == 3'h0 && duty_i != rco_pkg::DUTY_OFF && edge_any)
      |=> out_r == $past(rise_i);
  endproperty
  a_div0_half: assert property (p_div0_half) else $error("undivided output not 50%"); // RL9
endmodule

//--- hw/rco_top.sv
// reference clock output: Avalon-MM registers, source select and waveform shaper
`timescale 1ns/1ps
module rco_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [rco_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic system_osc_clock,
  input wire logic high_freq_internal_osc,
  input wire logic low_freq_internal_osc,
  input wire logic medium_freq_internal_osc_500k,
  input wire logic medium_freq_internal_osc_32k,
  input wire logic secondary_crystal_osc,
  input wire logic external_osc,
  input wire logic numeric_osc_output,
  input wire logic logic_cell_one_output,
  input wire logic logic_cell_two_output,
  input wire logic logic_cell_three_output,
  input wire logic logic_cell_four_output,
  input wire logic sleep_mode,
  input wire logic refclk_module_disable,
  output logic refclk_out_pin,
  output logic refclk_internal
);
  logic en_r;
  logic [1:0] duty_r;
  logic [2:0] div_r;
  logic [3:0] sel_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic req;
  logic accept;
  logic hit_ctrl;
  logic hit_src;
  logic wr_lane0;
  logic run_en;
  logic base_rise;
  logic base_fall;
  logic wave_out;
  logic [7:0] ctrl_view;
  logic [7:0] src_view;
  logic [rco_pkg::NUM_SRC-1:0] src_vec;

  // source vector in code order
  // [RL2] [RL3] source ordering
  assign src_vec = {
    logic_cell_four_output,
    logic_cell_three_output,
    logic_cell_two_output,
    logic_cell_one_output,
    numeric_osc_output,
    external_osc,
    secondary_crystal_osc,
    medium_freq_internal_osc_32k,
    medium_freq_internal_osc_500k,
    low_freq_internal_osc,
    high_freq_internal_osc,
    system_osc_clock
  };

  // bus decode; writes only land through byte lane 0
  assign req = avs_read | avs_write;
  assign accept = req & ~wait_r;
  assign hit_ctrl = (avs_address == rco_pkg::ADR_CTRL);
  assign hit_src = (avs_address == rco_pkg::ADR_SRC);
  assign wr_lane0 = accept & avs_write & avs_byteenable[0];

  // read views; unused bits read zero
  // [RL14] zero unused bits
  assign ctrl_view = {en_r, 2'h0, duty_r, div_r};
  assign src_view = {4'h0, sel_r};

  // one wait cycle per access gives read data a full cycle to settle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wait_r <= 1'b1;
    end
    else if (req && wait_r)
    begin
      wait_r <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  // read data prepared during the wait cycle, held until the next read
  // [RL13] disabled reads zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (avs_read && wait_r)
    begin
      if (refclk_module_disable)
      begin
        rdata_r <= 32'h0000_0000;
      end
      else if (hit_ctrl)
      begin
        rdata_r <= {24'h00_0000, ctrl_view};
      end
      else if (hit_src)
      begin
        rdata_r <= {24'h00_0000, src_view};
      end
      else
      begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // control register; module disable holds it at reset values
  // [RL10] [RL13] reset and disable values
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || refclk_module_disable)
    begin
      en_r <= 1'b0;
      duty_r <= rco_pkg::DUTY_RST;
      div_r <= rco_pkg::DIV_RST;
    end
    // [RL4] enable bit write
    else if (wr_lane0 && hit_ctrl)
    begin
      en_r <= avs_writedata[rco_pkg::EN_BIT];
      duty_r <= avs_writedata[rco_pkg::DUTY_MSB:rco_pkg::DUTY_LSB];
      div_r <= avs_writedata[rco_pkg::DIV_MSB:rco_pkg::DIV_LSB];
    end
  end

  // source select register
  // [RL14] source reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || refclk_module_disable)
    begin
      sel_r <= rco_pkg::SEL_RST;
    end
    else if (wr_lane0 && hit_src)
    begin
      sel_r <= avs_writedata[rco_pkg::SEL_MSB:0];
    end
  end

  // disable gates the shaper directly so the pin drops one edge later
  // [RL13] outputs off
  assign run_en = en_r & ~refclk_module_disable;

  rco_src_sel u_src (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_i(src_vec),
    .sel_i(sel_r),
    .sleep_i(sleep_mode),
    .rise_o(base_rise),
    .fall_o(base_fall)
  );

  rco_wave u_wave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .en_i(run_en),
    .duty_i(duty_r),
    .div_i(div_r),
    .rise_i(base_rise),
    .fall_i(base_fall),
    .out_r(wave_out)
  );

  // one shaper flip-flop feeds the pin and on-chip users alike
  // [RL1] shared output
  assign refclk_out_pin = wave_out;
  assign refclk_internal = wave_out;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  property p_pin_internal;
    @(posedge sys_clk) disable iff (!rst_n)
    refclk_out_pin == refclk_internal;
  endproperty
  a_pin_internal: assert property (p_pin_internal) else $error("pin and internal clock differ"); // RL1

  property p_reset_vals;
    @(posedge sys_clk)
    !rst_n |=> ctrl_view == rco_pkg::CTRL_RST && sel_r == rco_pkg::SEL_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // RL10

  property p_en_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lane0 && hit_ctrl && !refclk_module_disable)
      |=> en_r == $past(avs_writedata[rco_pkg::EN_BIT]) && duty_r == $past(avs_writedata[4:3]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("control write lost"); // RL4

  property p_disable_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    refclk_module_disable |=> !refclk_out_pin && ctrl_view == rco_pkg::CTRL_RST;
  endproperty
  a_disable_hold: assert property (p_disable_hold) else $error("disable did not hold block"); // RL13

  property p_disable_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (avs_read && wait_r && refclk_module_disable) |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_disable_read: assert property (p_disable_read) else $error("disabled read not zero"); // RL13

  property p_unused_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    (avs_read && wait_r && (hit_ctrl || hit_src))
      |=> avs_readdata[31:8] == 24'h00_0000 && (hit_src ? 1'b1 : avs_readdata[6:5] == 2'h0)
      && ($past(hit_src) ? avs_readdata[7:4] == 4'h0 : 1'b1);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // RL14

  sequence s_bus_req;
    req && wait_r;
  endsequence
  property p_bus_answer;
    @(posedge sys_clk) disable iff (!rst_n)
    s_bus_req |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no answer after one wait cycle");

  property p_stop_pin;
    @(posedge sys_clk) disable iff (!rst_n)
    (!en_r && !$past(en_r)) |-> !refclk_out_pin;
  endproperty
  a_stop_pin: assert property (p_stop_pin) else $error("pin active while disabled"); // RL6

  // an idle bus keeps the slave stalled so a new request always sees one wait cycle
  property p_wait_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    !req |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");

  // the answer stands for exactly one cycle
  property p_wait_one;
    @(posedge sys_clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice in a row");

  // source field takes the low nibble of an accepted write
  property p_sel_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lane0 && hit_src && !refclk_module_disable) |=> sel_r == $past(avs_writedata[rco_pkg::SEL_MSB:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("source write lost"); // RL2

  // divider field takes its bits of an accepted write
  property p_div_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lane0 && hit_ctrl && !refclk_module_disable)
      |=> div_r == $past(avs_writedata[rco_pkg::DIV_MSB:rco_pkg::DIV_LSB]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost"); // RL7

  // a write with lane 0 off must leave both registers alone
  property p_lane_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && avs_write && !avs_byteenable[0] && !refclk_module_disable) |=> $stable(ctrl_view) && $stable(sel_r);
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("lane-off write changed a register"); // RL14

  // control read returns the live register when the block is not disabled
  property p_read_ctrl;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && avs_read && hit_ctrl && !$past(refclk_module_disable)) |-> avs_readdata[7:0] == ctrl_view;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong"); // RL4

  // select read shows the field with the upper nibble zero
  property p_read_src;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && avs_read && hit_src && !$past(refclk_module_disable)) |-> avs_readdata[7:0] == src_view;
  endproperty
  a_read_src: assert property (p_read_src) else $error("select read wrong"); // RL14

  // disable clears the enable and the source field on the next edge
  property p_disable_regs;
    @(posedge sys_clk) disable iff (!rst_n)
    refclk_module_disable |=> !en_r && sel_r == rco_pkg::SEL_RST;
  endproperty
  a_disable_regs: assert property (p_disable_regs) else $error("disable left registers set"); // RL13

  // the gated enable drops the pin one edge later, whatever the shaper state
  property p_run_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    !run_en |=> !refclk_out_pin;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("pin high after run gate fell"); // RL6
endmodule

//--- test/rco_src_model.sv
// free-running source levels standing in for the oscillators and logic cells
`timescale 1ns/1ps
module rco_src_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic [11:0] src_o
);
  logic [3:0] cnt_r [12];
  // source i toggles every i+1 clocks so every code shows its own period
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (!rst_n || cnt_r[i] == 4'(i))
      begin
        cnt_r[i] <= 4'h0;
        src_o[i] <= rst_n ? ~src_o[i] : 1'b0;
      end
      else
        cnt_r[i] <= cnt_r[i] + 4'h1;
    end
  end
endmodule

//--- test/rco_tb.sv
// self-checking bench: register access, waveform shape, stop, sleep and module disable
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] avs_address = 14'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] src;
  logic sleep_mode = 1'b0;
  logic mod_dis = 1'b0;
  logic refclk_out_pin;
  logic refclk_internal;
  int err_total = 0;
  int check_count = 0;

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  rco_src_model u_src (.sys_clk(sys_clk), .rst_n(rst_n), .src_o(src));

  rco_top DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .system_osc_clock(src[0]), .high_freq_internal_osc(src[1]), .low_freq_internal_osc(src[2]),
    .medium_freq_internal_osc_500k(src[3]), .medium_freq_internal_osc_32k(src[4]),
    .secondary_crystal_osc(src[5]), .external_osc(src[6]), .numeric_osc_output(src[7]),
    .logic_cell_one_output(src[8]), .logic_cell_two_output(src[9]),
    .logic_cell_three_output(src[10]), .logic_cell_four_output(src[11]),
    .sleep_mode(sleep_mode), .refclk_module_disable(mod_dis),
    .refclk_out_pin(refclk_out_pin), .refclk_internal(refclk_internal)
  );

  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one avalon access; an extra edge after release keeps drivers from double assignment
  task bus(input logic wr, input logic [13:0] a, input logic [7:0] d, input logic [3:0] be,
           output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    // no cycle count is assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task rd_chk(input string name, input logic [13:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    check(name, q, exp);
  endtask

  task cfg(input logic [3:0] s, input logic [1:0] d, input logic [2:0] v);
    wr(rco_pkg::ADR_CTRL, {3'h0, d, v});
    wr(rco_pkg::ADR_SRC, {4'h0, s});
    wr(rco_pkg::ADR_CTRL, {3'h4, d, v});
  endtask

  // counts clocks until the pin reaches the level, bounded
  task wait_level(input logic lv, output int n);
    n = 0;
    while (refclk_out_pin !== lv && n < 2000)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task count_high(input int cyc, output int hi);
    hi = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk);
      if (refclk_out_pin !== 1'b0)
        hi++;
    end
  endtask

  // first full pulse after enable is measured, so a runt shows as a short high count
  task check_wave(input logic [3:0] s, input logic [1:0] d, input logic [2:0] v);
    int h, per, hi, lo, n;
    h = int'(s) + 1;
    per = (1 << v) * 2 * h;
    cfg(s, d, v);
    if (s >= 4'hC || d == 2'h0)
    begin
      count_high(300, hi);
      check("idle high cycles", 32'(hi), 32'h0);
    end
    else
    begin
      wait_level(1'b1, n);
      check("internal copy", {31'h0, refclk_internal}, {31'h0, refclk_out_pin});
      wait_level(1'b0, hi);
      wait_level(1'b1, lo);
      check("high cycles", 32'(hi), 32'((v == 3'h0) ? h : per * int'(d) / 4));
      check("low cycles", 32'(lo), 32'((v == 3'h0) ? h : per - per * int'(d) / 4));
    end
  endtask

  task reg_access;
    logic [31:0] q;
    rd_chk("ctrl reset", rco_pkg::ADR_CTRL, 32'h10);
    rd_chk("select reset", rco_pkg::ADR_SRC, 32'h0);
    wr(rco_pkg::ADR_CTRL, 8'h67);
    rd_chk("ctrl unused bits", rco_pkg::ADR_CTRL, 32'h07);
    wr(rco_pkg::ADR_SRC, 8'hF3);
    rd_chk("select unused bits", rco_pkg::ADR_SRC, 32'h03);
    bus(1'b1, rco_pkg::ADR_CTRL, 8'h1F, 4'h0, q);
    rd_chk("ctrl lane off", rco_pkg::ADR_CTRL, 32'h07);
    wr(14'h0000, 8'hFF);
    rd_chk("unmapped", 14'h0000, 32'h0);
  endtask

  // clearing enable mid-pulse must cut the high phase short
  task stop_midpulse;
    int n, hi;
    cfg(4'hB, 2'h3, 3'h3);
    wait_level(1'b1, n);
    repeat (10) @(posedge sys_clk);
    wr(rco_pkg::ADR_CTRL, 8'h1B);
    repeat (2) @(posedge sys_clk);
    count_high(300, hi);
    check("high after stop", 32'(hi), 32'h0);
  endtask

  task sleep_run;
    int hi;
    sleep_mode <= 1'b1;
    check_wave(4'h1, 2'h2, 3'h0);
    cfg(4'h0, 2'h2, 3'h0);
    count_high(300, hi);
    check("system source in sleep", 32'(hi), 32'h0);
    sleep_mode <= 1'b0;
    @(posedge sys_clk);
  endtask

  task disable_run;
    int hi;
    cfg(4'h1, 2'h2, 3'h1);
    mod_dis <= 1'b1;
    rd_chk("ctrl disabled", rco_pkg::ADR_CTRL, 32'h0);
    wr(rco_pkg::ADR_SRC, 8'h05);
    rd_chk("select disabled", rco_pkg::ADR_SRC, 32'h0);
    count_high(50, hi);
    check("high while disabled", 32'(hi), 32'h0);
    mod_dis <= 1'b0;
    @(posedge sys_clk);
    rd_chk("ctrl after disable", rco_pkg::ADR_CTRL, 32'h10);
    rd_chk("select after disable", rco_pkg::ADR_SRC, 32'h0);
  endtask

  // main sequence: reset for six clocks, then every scenario in turn
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    reg_access;
    for (int s = 0; s < 13; s++) check_wave(4'(s), 2'h2, 3'h1);
    for (int v = 0; v < 8; v++) check_wave(4'h0, 2'h2, 3'(v));
    for (int d = 0; d < 4; d++)
    begin
      check_wave(4'h2, 2'(d), 3'h2);
      check_wave(4'h2, 2'(d), 3'h0);
    end
    stop_midpulse;
    sleep_run;
    disable_run;
    test_done;
  end

  // watchdog well beyond the expected few thousand clocks
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done;
  end
endmodule
